// ===== digital_io_animation_player.sv
// Purpose: digital input/output bank with level compare, edge watch,
//          direct drive and 60 Hz one-bit animation playback
// Assumes: commands one at a time under cmdValid/cmdReady
// Notes: frame work scans all eight outputs within one frame period
`timescale 1ns/1ps
`default_nettype none
`include "dio_defs.svh"
// Behaviour
// - every channel is either on (1) or off (0).
// - compare returns the channel's present level, no history involved.
// - a watch fires only on a change into the wanted state.
// - after firing, a watch stays quiet until the next such change.
// - outputs can be compared and watched using their driven level.
// - on drives the named outputs to 1.
// - off drives the named outputs to 0.
// - set acts as on for non-zero value, off for zero.
// - queue binds a sequence and loads it fully into memory first.
// - samples below half scale drive off, above half drive on.
// - start plays from the first sample after queue, else from position.
// - start after pause resumes exactly where the pause took effect.
// - pause halts and keeps position; no effect when not playing.
// - stop ends playback and rewinds to the first sample.
module digital_io_animation_player #(
    parameter int unsigned FRAME_CYCLES = `DIO_FRAME_CYC
) (
    input wire logic clk,
    input wire logic rst,
    // command port
    input wire logic cmdValid,
    output logic cmdReady_r,
    input wire logic [3:0] cmdOp,
    input wire logic [`DIO_NCH-1:0] cmdMask,
    input wire logic [`DIO_CW-1:0] cmdChan,
    input wire logic cmdBank,
    input wire logic [`DIO_SW-1:0] cmdValue,
    // sequence load stream
    input wire logic loadValid,
    output logic loadReady_r,
    input wire logic [`DIO_SW-1:0] loadSample,
    input wire logic loadLast,
    // channel levels
    input wire logic [`DIO_NCH-1:0] inLevel,
    output logic [`DIO_NCH-1:0] outLevel_r,
    // answers and events
    output logic cmpValid_r,
    output logic cmpLevel_r,
    output logic [`DIO_NCH-1:0] inEvent_r,
    output logic [`DIO_NCH-1:0] outEvent_r,
    output logic [`DIO_NCH-1:0] playing_r
);
    dio_pkg::state_type st_r, stNxt;
    dio_pkg::op_type op;
    logic accept, loadAcc, loadEnd, tickPend_r, tickNxt, frameTick_r;
    logic [`DIO_FCW-1:0] frameCnt_r;
    logic [3:0] scanIdx_r;
    logic [`DIO_CW-1:0] rdCh_r;
    logic rdValid_r;
    logic [`DIO_AW-1:0] rdAddr;
    logic [`DIO_MW-1:0] rdData;
    logic [1:0] code;
    logic advance;
    logic [`DIO_AW-1:0] pos_r [`DIO_NCH];
    logic [`DIO_LW-1:0] len_r [`DIO_NCH];
    logic [`DIO_NCH-1:0] bound_r, qMask_r, posZero;
    logic [`DIO_AW-1:0] loadIdx_r;
    logic [`DIO_NCH-1:0] armIn, armOut, disIn, disOut;

    // half scale is neither on nor off, so the level is held
    function automatic logic [1:0] sampleCode(input logic [`DIO_SW-1:0] s);
        if (s < `DIO_HALF) begin
            return `DIO_CODE_OFF;
        end else if (s > `DIO_HALF) begin
            return `DIO_CODE_ON;
        end
        return `DIO_CODE_HOLD;
    endfunction

    function automatic logic [`DIO_NCH-1:0] drive(
        input logic [`DIO_NCH-1:0] cur,
        input logic [`DIO_NCH-1:0] m,
        input logic on);
        return on ? (cur | m) : (cur & ~m);
    endfunction

    function automatic logic atEnd(
        input logic [`DIO_AW-1:0] p,
        input logic [`DIO_LW-1:0] l);
        return ({1'b0, p} + 7'h01) >= l;
    endfunction

    assign op = dio_pkg::op_type'(cmdOp);
    assign accept = cmdValid && cmdReady_r;
    assign loadAcc = loadValid && loadReady_r;
    assign loadEnd = loadAcc && (loadLast || loadIdx_r == `DIO_LAST_ADDR);
    assign rdAddr = pos_r[scanIdx_r[`DIO_CW-1:0]];
    assign code = rdData[2*rdCh_r +: 2];
    assign advance = rdValid_r && playing_r[rdCh_r];

    always_comb begin
        for (int i = 0; i < `DIO_NCH; i++) begin
            posZero[i] = pos_r[i] == '0;
        end
    end

    // frame clock for 60 samples a second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            frameCnt_r <= '0;
            frameTick_r <= 1'b0;
        end else if (frameCnt_r == `DIO_FCW'(FRAME_CYCLES - 1)) begin
            frameCnt_r <= '0;
            frameTick_r <= 1'b1;
        end else begin
            frameCnt_r <= frameCnt_r + 1'b1;
            frameTick_r <= 1'b0;
        end
    end

    // a tick during load is kept pending; a new tick wins over the clear
    always_comb begin
        stNxt = st_r;
        tickNxt = tickPend_r | frameTick_r;
        unique case (st_r)
            dio_pkg::ST_IDLE: begin
                if (accept && op == dio_pkg::OP_QUEUE) begin
                    stNxt = dio_pkg::ST_LOAD;
                end else if (!accept && tickPend_r) begin
                    stNxt = dio_pkg::ST_SCAN;
                    tickNxt = frameTick_r;
                end
            end
            dio_pkg::ST_SCAN: begin
                if (scanIdx_r == `DIO_SCAN_END) begin
                    stNxt = dio_pkg::ST_IDLE;
                end
            end
            dio_pkg::ST_LOAD: begin
                if (loadEnd) begin
                    stNxt = dio_pkg::ST_IDLE;
                end
            end
            default: stNxt = dio_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= dio_pkg::ST_IDLE;
            tickPend_r <= 1'b0;
            cmdReady_r <= 1'b0;
            loadReady_r <= 1'b0;
        end else begin
            st_r <= stNxt;
            tickPend_r <= tickNxt;
            cmdReady_r <= stNxt == dio_pkg::ST_IDLE && !tickNxt;
            loadReady_r <= stNxt == dio_pkg::ST_LOAD;
        end
    end

    // scan: one read per channel, data comes back a cycle later
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scanIdx_r <= '0;
            rdCh_r <= '0;
            rdValid_r <= 1'b0;
        end else if (st_r == dio_pkg::ST_SCAN &&
                     scanIdx_r != `DIO_SCAN_END) begin
            rdCh_r <= scanIdx_r[`DIO_CW-1:0];
            rdValid_r <= 1'b1;
            scanIdx_r <= scanIdx_r + 1'b1;
        end else begin
            rdValid_r <= 1'b0;
            if (st_r != dio_pkg::ST_SCAN) begin
                scanIdx_r <= '0;
            end
        end
    end

    // sequence loading into the bound lanes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            loadIdx_r <= '0;
            qMask_r <= '0;
            bound_r <= '0;
            for (int i = 0; i < `DIO_NCH; i++) begin
                len_r[i] <= '0;
            end
        end else if (accept && op == dio_pkg::OP_QUEUE) begin
            loadIdx_r <= '0;
            qMask_r <= cmdMask;
            bound_r <= bound_r & ~cmdMask;
        end else if (loadAcc) begin
            loadIdx_r <= loadIdx_r + 1'b1;
            if (loadEnd) begin
                bound_r <= bound_r | qMask_r;
                for (int i = 0; i < `DIO_NCH; i++) begin
                    if (qMask_r[i]) begin
                        len_r[i] <= {1'b0, loadIdx_r} + 7'h01;
                    end
                end
            end
        end
    end

    anim_mem u_mem (
        .clk(clk),
        .rst(rst),
        .wrEn(loadAcc),
        .wrLanes(qMask_r),
        .wrAddr(loadIdx_r),
        .wrCode(sampleCode(loadSample)),
        .rdAddr(rdAddr),
        .rdData(rdData)
    );

    // playback state and position
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            playing_r <= '0;
            for (int i = 0; i < `DIO_NCH; i++) begin
                pos_r[i] <= '0;
            end
        end else if (accept) begin
            unique case (op)
                dio_pkg::OP_START:
                    playing_r <= playing_r | (cmdMask & bound_r);
                dio_pkg::OP_PAUSE:
                    playing_r <= playing_r & ~cmdMask;
                dio_pkg::OP_STOP, dio_pkg::OP_QUEUE: begin
                    playing_r <= playing_r & ~cmdMask;
                    for (int i = 0; i < `DIO_NCH; i++) begin
                        if (cmdMask[i]) begin
                            pos_r[i] <= '0;
                        end
                    end
                end
                default: ;
            endcase
        end else if (advance) begin
            // at the end of a sequence playback stops and rewinds
            if (atEnd(pos_r[rdCh_r], len_r[rdCh_r])) begin
                playing_r[rdCh_r] <= 1'b0;
                pos_r[rdCh_r] <= '0;
            end else begin
                pos_r[rdCh_r] <= pos_r[rdCh_r] + 1'b1;
            end
        end
    end

    // output drive: direct requests and animation samples
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outLevel_r <= '0;
        end else if (accept) begin
            unique case (op)
                dio_pkg::OP_ON:
                    outLevel_r <= drive(outLevel_r, cmdMask, 1'b1);
                dio_pkg::OP_OFF:
                    outLevel_r <= drive(outLevel_r, cmdMask, 1'b0);
                dio_pkg::OP_SET:
                    outLevel_r <= drive(outLevel_r, cmdMask,
                                        cmdValue != '0);
                default: ;
            endcase
        end else if (advance && code != `DIO_CODE_HOLD) begin
            outLevel_r[rdCh_r] <= code == `DIO_CODE_ON;
        end
    end

    // level compare on either bank
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmpValid_r <= 1'b0;
            cmpLevel_r <= 1'b0;
        end else begin
            cmpValid_r <= accept && op == dio_pkg::OP_COMPARE;
            if (accept && op == dio_pkg::OP_COMPARE) begin
                cmpLevel_r <= cmdBank ? outLevel_r[cmdChan]
                                      : inLevel[cmdChan];
            end
        end
    end

    assign armIn = (accept && op == dio_pkg::OP_WATCH && !cmdBank)
                   ? cmdMask : '0;
    assign armOut = (accept && op == dio_pkg::OP_WATCH && cmdBank)
                    ? cmdMask : '0;
    assign disIn = (accept && op == dio_pkg::OP_UNWATCH && !cmdBank)
                   ? cmdMask : '0;
    assign disOut = (accept && op == dio_pkg::OP_UNWATCH && cmdBank)
                    ? cmdMask : '0;

    edge_watch u_inWatch (
        .clk(clk),
        .rst(rst),
        .level(inLevel),
        .armMask(armIn),
        .disarmMask(disIn),
        .desired(cmdValue != '0),
        .event_r(inEvent_r)
    );

    // outputs are watched on their driven level
    edge_watch u_outWatch (
        .clk(clk),
        .rst(rst),
        .level(outLevel_r),
        .armMask(armOut),
        .disarmMask(disOut),
        .desired(cmdValue != '0),
        .event_r(outEvent_r)
    );

    AST_ON_DRIVES: assert property (@(posedge clk) disable iff (rst)
        accept && op == dio_pkg::OP_ON |=>
        (outLevel_r & $past(cmdMask)) == $past(cmdMask))
        else $error("on did not drive outputs high");

    AST_OFF_DRIVES: assert property (@(posedge clk) disable iff (rst)
        accept && op == dio_pkg::OP_OFF |=>
        (outLevel_r & $past(cmdMask)) == '0)
        else $error("off did not drive outputs low");

    AST_SET_ZERO: assert property (@(posedge clk) disable iff (rst)
        accept && op == dio_pkg::OP_SET && cmdValue == '0 |=>
        (outLevel_r & $past(cmdMask)) == '0)
        else $error("set zero did not act as off");

    AST_CMP_NOW: assert property (@(posedge clk) disable iff (rst)
        accept && op == dio_pkg::OP_COMPARE && !cmdBank |=>
        cmpValid_r && cmpLevel_r == $past(inLevel[cmdChan]))
        else $error("compare did not return present level");

    AST_QUEUE_LOAD: assert property (@(posedge clk) disable iff (rst)
        accept && op == dio_pkg::OP_QUEUE |=>
        st_r == dio_pkg::ST_LOAD && (playing_r & $past(cmdMask)) == '0)
        else $error("queue did not enter loading");

    AST_START_PLAYS: assert property (@(posedge clk) disable iff (rst)
        accept && op == dio_pkg::OP_START |=>
        (playing_r & $past(cmdMask & bound_r)) == $past(cmdMask & bound_r))
        else $error("start did not begin playback");

    AST_PAUSE_KEEPS: assert property (@(posedge clk) disable iff (rst)
        accept && op == dio_pkg::OP_PAUSE |=>
        (playing_r & $past(cmdMask)) == '0 && pos_r[0] == $past(pos_r[0]))
        else $error("pause did not hold position");

    AST_STOP_REWINDS: assert property (@(posedge clk) disable iff (rst)
        accept && op == dio_pkg::OP_STOP |=>
        (posZero & $past(cmdMask)) == $past(cmdMask))
        else $error("stop did not rewind");

    AST_SCAN_BOUNDED: assert property (@(posedge clk) disable iff (rst)
        st_r == dio_pkg::ST_IDLE && stNxt == dio_pkg::ST_SCAN |=>
        ##[8:9] st_r == dio_pkg::ST_IDLE)
        else $error("frame scan overran");
endmodule // digital_io_animation_player
`default_nettype wire

// ===== dio_defs.svh
// Purpose: shared constants for the digital i/o animation player
// Assumes: 200 MHz clock, eight input and eight output channels
// Notes: included by bare name; definitions only
`ifndef DIO_DEFS_SVH
`define DIO_DEFS_SVH

`define DIO_NCH 8
`define DIO_CW 3
`define DIO_DEPTH 64
`define DIO_AW 6
`define DIO_LW 7
`define DIO_SW 8
`define DIO_MW 16
`define DIO_HALF 8'h80
`define DIO_LAST_ADDR 6'h3f
`define DIO_SCAN_END 4'h8
`define DIO_CLK_HZ 200000000
`define DIO_FRAME_HZ 60
`define DIO_FRAME_CYC (`DIO_CLK_HZ / `DIO_FRAME_HZ)
`define DIO_FCW 22
`define DIO_CODE_OFF 2'h0
`define DIO_CODE_ON 2'h1
`define DIO_CODE_HOLD 2'h2

`endif

// ===== dio_pkg.sv
// Purpose: types for the digital i/o animation player
// Assumes: nothing beyond the defs header
// Notes: op and state codes
package dio_pkg;

    typedef enum logic [3:0] {
        OP_ON = 4'h0,
        OP_OFF = 4'h1,
        OP_SET = 4'h2,
        OP_QUEUE = 4'h3,
        OP_START = 4'h4,
        OP_PAUSE = 4'h5,
        OP_STOP = 4'h6,
        OP_COMPARE = 4'h7,
        OP_WATCH = 4'h8,
        OP_UNWATCH = 4'h9
    } op_type;

    // gray along idle->scan->idle and idle->load->idle
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_SCAN = 2'h1,
        ST_LOAD = 2'h2
    } state_type;

endpackage

// ===== anim_mem.sv
// Purpose: sample store, one 2-bit lane per output channel
// Assumes: single write port with lane enables, registered read
// Notes: address is the sample index shared by all lanes
`timescale 1ns/1ps
`default_nettype none
`include "dio_defs.svh"
module anim_mem (
    input wire logic clk,
    input wire logic rst,
    // write side
    input wire logic wrEn,
    input wire logic [`DIO_NCH-1:0] wrLanes,
    input wire logic [`DIO_AW-1:0] wrAddr,
    input wire logic [1:0] wrCode,
    // read side
    input wire logic [`DIO_AW-1:0] rdAddr,
    output logic [`DIO_MW-1:0] rdData
);
    logic [`DIO_MW-1:0] mem [`DIO_DEPTH];

    always_ff @(posedge clk) begin
        for (int i = 0; i < `DIO_NCH; i++) begin
            if (wrEn && wrLanes[i]) begin
                mem[wrAddr][2*i +: 2] <= wrCode;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdData <= '0;
        end else begin
            rdData <= mem[rdAddr];
        end
    end
endmodule // anim_mem
`default_nettype wire

// ===== edge_watch.sv
// Purpose: edge-qualified watches on a bank of channel levels
// Assumes: levels synchronous to clk
// Notes: one event pulse per entry into the wanted state
`timescale 1ns/1ps
`default_nettype none
`include "dio_defs.svh"
module edge_watch (
    input wire logic clk,
    input wire logic rst,
    // levels watched
    input wire logic [`DIO_NCH-1:0] level,
    // arming
    input wire logic [`DIO_NCH-1:0] armMask,
    input wire logic [`DIO_NCH-1:0] disarmMask,
    input wire logic desired,
    // events
    output logic [`DIO_NCH-1:0] event_r
);
    logic [`DIO_NCH-1:0] armed_r;
    logic [`DIO_NCH-1:0] want_r;
    logic [`DIO_NCH-1:0] prev_r;
    logic [`DIO_NCH-1:0] fire;

    // prev taken on the arm cycle, so a level already there is no edge
    assign fire = armed_r & ~(level ^ want_r) & (prev_r ^ want_r);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_r <= '0;
            event_r <= '0;
        end else begin
            prev_r <= level;
            event_r <= fire;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            armed_r <= '0;
            want_r <= '0;
        end else begin
            armed_r <= (armed_r & ~disarmMask) | armMask;
            for (int i = 0; i < `DIO_NCH; i++) begin
                if (armMask[i]) begin
                    want_r[i] <= desired;
                end
            end
        end
    end

    AST_EDGE_ONLY: assert property (@(posedge clk) disable iff (rst)
        (|event_r) |->
        ((($past(prev_r) ^ $past(level)) & event_r) == event_r))
        else $error("event without a level change");

    AST_NO_REFIRE: assert property (@(posedge clk) disable iff (rst)
        (|event_r) |=> ((event_r & $past(event_r)) == '0))
        else $error("event fired twice on one edge");
endmodule // edge_watch
`default_nettype wire

// ===== field_model.sv
// Purpose: field-side model of contacts and relays on the channel bank
// Assumes: contacts settle within one clock of a change
// Notes: loopBack wires each relay output back onto its sense input
`timescale 1ns/1ps
`default_nettype none
module field_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // scenario control
    input wire logic [7:0] contactSet,
    input wire logic loopBack,
    // channel bank
    input wire logic [7:0] outLevel,
    output logic [7:0] inLevel
);
    // contacts are two-state only, so no float ever reaches the bank
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            inLevel <= 8'h00;
        end else if (loopBack) begin
            inLevel <= outLevel;
        end else begin
            inLevel <= contactSet;
        end
    end
endmodule // field_model
`default_nettype wire

// ===== tb_digital_io_animation_player.sv
// Purpose: self-checking bench for the digital i/o animation player
// Assumes: frame period shortened to 40 clocks
// Notes: events and playback changes are counted at the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_digital_io_animation_player;
    typedef struct packed {
        logic [3:0] op;
        logic [7:0] mask;
        logic [7:0] value;
        logic [7:0] contacts;
        logic [2:0] chan;
        logic [7:0] expOut;
    } row_type;
    localparam row_type ROWS[7] = '{
        '{dio_pkg::OP_ON, 8'h0f, 8'h00, 8'ha5, 3'h0, 8'h0f},
        '{dio_pkg::OP_OFF, 8'h05, 8'h00, 8'h5a, 3'h1, 8'h0a},
        '{dio_pkg::OP_SET, 8'h30, 8'h01, 8'hff, 3'h4, 8'h3a},
        '{dio_pkg::OP_SET, 8'h02, 8'h00, 8'h00, 3'h1, 8'h38},
        '{dio_pkg::OP_SET, 8'hc0, 8'h80, 8'h81, 3'h7, 8'hf8},
        '{dio_pkg::OP_SET, 8'h08, 8'h00, 8'h3c, 3'h3, 8'hf0},
        '{dio_pkg::OP_OFF, 8'hff, 8'h00, 8'hc3, 3'h6, 8'h00}};
    // half scale sits between real levels so it shows up as a hold
    localparam logic [7:0] SEQ[7] = '{8'h00, 8'hff, 8'h80, 8'hff, 8'h10,
        8'h80, 8'h00};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cmdValid = 1'b0;
    logic [3:0] cmdOp = 4'h0;
    logic [7:0] cmdMask = 8'h00;
    logic [2:0] cmdChan = 3'h0;
    logic cmdBank = 1'b0;
    logic [7:0] cmdValue = 8'h00;
    logic loadValid = 1'b0;
    logic [7:0] loadSample = 8'h00;
    logic loadLast = 1'b0;
    logic [7:0] contactSet = 8'h00;
    logic loopBack = 1'b0;
    logic [7:0] inLevel, outLevel, inEvent, outEvent, playing;
    logic cmdReady, loadReady, cmpValid, cmpLevel;
    logic [1:0] prevOut = 2'b00;
    logic [7:0] hist[2];
    int transCnt[2];
    int inEvCnt[8];
    int outEvCnt[8];
    int fail_count = 0;
    int comparisons = 0;

    always #2.5 clk = ~clk;

    digital_io_animation_player #(.FRAME_CYCLES(40)) dut_u (
        .clk(clk), .rst(rst), .cmdValid(cmdValid), .cmdReady_r(cmdReady),
        .cmdOp(cmdOp), .cmdMask(cmdMask), .cmdChan(cmdChan),
        .cmdBank(cmdBank), .cmdValue(cmdValue), .loadValid(loadValid),
        .loadReady_r(loadReady), .loadSample(loadSample),
        .loadLast(loadLast), .inLevel(inLevel), .outLevel_r(outLevel),
        .cmpValid_r(cmpValid), .cmpLevel_r(cmpLevel),
        .inEvent_r(inEvent), .outEvent_r(outEvent), .playing_r(playing));

    field_model field_u (
        .clk(clk), .rst(rst), .contactSet(contactSet),
        .loopBack(loopBack), .outLevel(outLevel), .inLevel(inLevel));

    always @(negedge clk) begin
        for (int i = 0; i < 8; i++) begin
            inEvCnt[i] += (inEvent[i] === 1'b1) ? 1 : 0;
            outEvCnt[i] += (outEvent[i] === 1'b1) ? 1 : 0;
        end
        for (int i = 0; i < 2; i++) begin
            if (outLevel[i] !== prevOut[i]) begin
                transCnt[i]++;
                hist[i] = {hist[i][6:0], outLevel[i]};
            end
        end
        prevOut = outLevel[1:0];
    end

    task automatic conclude;
        if (fail_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic timeoutHit;
        fail_count++;
        conclude();
    endtask

    task automatic checkBits(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic checkNum(input int got, input int exp);
        comparisons++;
        if (got != exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // waits for the taking edge and returns at the falling edge after it
    task automatic sendCmd(input logic [3:0] op, input logic [7:0] mask,
            input logic [7:0] value, input logic bank,
            input logic [2:0] chan);
        int n;
        @(posedge clk);
        cmdValid <= 1'b1;
        cmdOp <= op;
        cmdMask <= mask;
        cmdValue <= value;
        cmdBank <= bank;
        cmdChan <= chan;
        n = 0;
        @(negedge clk);
        while (cmdReady !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 2000) timeoutHit();
        @(posedge clk);
        cmdValid <= 1'b0;
        @(negedge clk);
    endtask

    task automatic loadSeq;
        int n;
        for (int k = 0; k < 7; k++) begin
            @(posedge clk);
            loadValid <= 1'b1;
            loadSample <= SEQ[k];
            loadLast <= (k == 6);
            n = 0;
            @(negedge clk);
            while (loadReady !== 1'b1 && n < 200) begin
                @(negedge clk);
                n++;
            end
            if (n >= 200) timeoutHit();
        end
        @(posedge clk);
        loadValid <= 1'b0;
        loadLast <= 1'b0;
    endtask

    task automatic settle;
        repeat (8) @(posedge clk);
    endtask

    task automatic setContacts(input logic [7:0] v);
        @(posedge clk);
        contactSet <= v;
        settle();
    endtask

    task automatic clearCounts;
        for (int i = 0; i < 8; i++) begin
            inEvCnt[i] = 0;
            outEvCnt[i] = 0;
        end
        for (int i = 0; i < 2; i++) begin
            transCnt[i] = 0;
            hist[i] = 8'h00;
        end
    endtask

    task automatic waitFirstChange;
        int n;
        n = 0;
        while (transCnt[0] < 1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 1000) timeoutHit();
    endtask

    task automatic waitPlayDone;
        int n;
        n = 0;
        while (playing[1:0] !== 2'b00 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 1000) timeoutHit();
        settle();
    endtask

    task automatic checkPlay(input int cnt, input logic [7:0] h);
        checkNum(transCnt[0], cnt);
        checkBits(hist[0], h);
    endtask

    initial begin
        repeat (8) @(negedge clk);
        checkBits(outLevel | playing | inEvent | outEvent, 8'h00);
        checkBits({5'h00, cmdReady, loadReady, cmpValid}, 8'h00);
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int r = 0; r < 7; r++) begin
            setContacts(ROWS[r].contacts);
            sendCmd(ROWS[r].op, ROWS[r].mask, ROWS[r].value, 1'b0, 3'h0);
            checkBits(outLevel, ROWS[r].expOut);
            sendCmd(dio_pkg::OP_COMPARE, 8'h00, 8'h00, 1'b1, ROWS[r].chan);
            checkBits({6'h00, cmpValid, cmpLevel},
                {6'h00, 1'b1, ROWS[r].expOut[ROWS[r].chan]});
            sendCmd(dio_pkg::OP_COMPARE, 8'h00, 8'h00, 1'b0, ROWS[r].chan);
            checkBits({6'h00, cmpValid, cmpLevel},
                {6'h00, 1'b1, ROWS[r].contacts[ROWS[r].chan]});
        end
        // a watch armed on a channel already in the wanted state
        setContacts(8'h02);
        sendCmd(dio_pkg::OP_WATCH, 8'h03, 8'h01, 1'b0, 3'h0);
        settle();
        clearCounts();
        setContacts(8'h03);
        setContacts(8'h03);
        checkNum(inEvCnt[1], 0);
        checkNum(inEvCnt[0], 1);
        setContacts(8'h00);
        setContacts(8'h01);
        checkNum(inEvCnt[0], 2);
        checkNum(inEvCnt[1], 0);
        sendCmd(dio_pkg::OP_ON, 8'h10, 8'h00, 1'b0, 3'h0);
        sendCmd(dio_pkg::OP_WATCH, 8'h10, 8'h00, 1'b1, 3'h0);
        sendCmd(dio_pkg::OP_OFF, 8'h10, 8'h00, 1'b0, 3'h0);
        sendCmd(dio_pkg::OP_OFF, 8'h10, 8'h00, 1'b0, 3'h0);
        settle();
        checkNum(outEvCnt[4], 1);
        // relay wired back: driven level reaches the sense side
        loopBack <= 1'b1;
        settle();
        sendCmd(dio_pkg::OP_WATCH, 8'h04, 8'h01, 1'b0, 3'h0);
        sendCmd(dio_pkg::OP_ON, 8'h04, 8'h00, 1'b0, 3'h0);
        settle();
        checkNum(inEvCnt[2], 1);
        sendCmd(dio_pkg::OP_UNWATCH, 8'h04, 8'h00, 1'b0, 3'h0);
        sendCmd(dio_pkg::OP_OFF, 8'hff, 8'h00, 1'b0, 3'h0);
        sendCmd(dio_pkg::OP_ON, 8'h04, 8'h00, 1'b0, 3'h0);
        sendCmd(dio_pkg::OP_OFF, 8'h04, 8'h00, 1'b0, 3'h0);
        settle();
        checkNum(inEvCnt[2], 1);
        // playback on two channels from one queued sequence
        clearCounts();
        sendCmd(dio_pkg::OP_QUEUE, 8'h03, 8'h00, 1'b0, 3'h0);
        loadSeq();
        sendCmd(dio_pkg::OP_START, 8'h03, 8'h00, 1'b0, 3'h0);
        checkBits(playing, 8'h03);
        waitPlayDone();
        checkPlay(2, 8'h02);
        checkNum(transCnt[1], 2);
        checkBits(hist[1], 8'h02);
        // pause keeps the position
        clearCounts();
        sendCmd(dio_pkg::OP_START, 8'h01, 8'h00, 1'b0, 3'h0);
        waitFirstChange();
        sendCmd(dio_pkg::OP_PAUSE, 8'h01, 8'h00, 1'b0, 3'h0);
        checkBits(playing, 8'h00);
        repeat (120) @(posedge clk);
        checkNum(transCnt[0], 1);
        sendCmd(dio_pkg::OP_START, 8'h01, 8'h00, 1'b0, 3'h0);
        waitPlayDone();
        checkPlay(2, 8'h02);
        // stop rewinds to the first sample
        clearCounts();
        sendCmd(dio_pkg::OP_START, 8'h01, 8'h00, 1'b0, 3'h0);
        waitFirstChange();
        sendCmd(dio_pkg::OP_STOP, 8'h01, 8'h00, 1'b0, 3'h0);
        checkBits(playing, 8'h00);
        sendCmd(dio_pkg::OP_START, 8'h01, 8'h00, 1'b0, 3'h0);
        waitPlayDone();
        checkPlay(4, 8'h0a);
        // reset in mid-run clears the driven levels
        sendCmd(dio_pkg::OP_ON, 8'hff, 8'h00, 1'b0, 3'h0);
        @(posedge clk);
        rst <= 1'b1;
        @(negedge clk);
        checkBits(outLevel | playing, 8'h00);
        @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(negedge clk);
        checkBits({outLevel[6:0], cmdReady}, 8'h01);
        conclude();
    end
endmodule // tb_digital_io_animation_player
`default_nettype wire
